/* File: verilog/rsf_map.svh */
// register offsets, field positions, reset values and timing counts
// Summary of operation
// - power-on flag set at reset, software clears
// - low-voltage flag sticks until software writes zero
// - compensation suspended while supply below threshold
// - register 0Eh upper nibble holds temperature fraction
// - lower nibble: write-fail, busy, clock-event, switchover
// - three event flags clear-only, writes never set
// - busy flag read-only, zero means transfer done
// - failed nvm write below 1.3 V sets flag
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RSF_ADDR_STATUS     8'h0D
`define RSF_ADDR_TEMP_LSB   8'h0E
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSF_BIT_LOW_VOLT    0
`define RSF_BIT_POWER_ON    1
`define RSF_BIT_SWITCH      0
`define RSF_BIT_CLK_EVT     1
`define RSF_BIT_BUSY        2
`define RSF_BIT_WR_FAIL     3
`define RSF_FRAC_LSB        4
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RSF_RST_POWER_ON    1'b1
`define RSF_RST_FLAG        1'b0
`define RSF_RST_BUSY        1'b1
`define RSF_RST_FRAC        4'h0
`define RSF_BUSY_CYCLES     16'h0010
`endif

/* File: verilog/rsf_pkg.sv */
// types shared by the status and temperature-flag block
package rsf_pkg;
  // busy sequencing states, gray along the path
  typedef enum logic [1:0] {
    RSF_BOOT = 2'b00,
    RSF_BUSY = 2'b01,
    RSF_IDLE = 2'b11
  } rsf_state_t;
endpackage

/* File: verilog/rsf_sync.sv */
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module rsf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d_async,
  output logic      [WIDTH-1:0] q_sync
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by second

  // a zero-width bus cannot be synchronised
  if (WIDTH < 1) begin : g_width_chk
    $error("WIDTH out of range");
  end

  // ------------------------------------------------------------
  // two stages
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q_sync <= '0;
    end else if (clk_en) begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule

/* File: verilog/rsf_flags.sv */
// status flags and temperature fraction register of the clock
`timescale 1ns/1ps
`include "rsf_map.svh"
module rsf_flags import rsf_pkg::*; #(
  parameter int BUSY_CYCLES = `RSF_BUSY_CYCLES
) (
  input  wire logic       clk_sys,      // 40 MHz system clock
  input  wire logic       rst,          // power-on reset, active high
  input  wire logic       clk_en,       // freezes state when low
  input  wire logic [7:0] reg_addr,     // register address
  input  wire logic [7:0] reg_wdata,    // write data
  input  wire logic       reg_wr,       // write strobe
  input  wire logic       reg_rd,       // read strobe
  output logic      [7:0] reg_rdata,    // read data, registered
  output logic            reg_rvalid,   // read data valid pulse
  input  wire logic       supply_low,   // supply below threshold (async)
  input  wire logic       nvm_fail,     // nvm write failed (async)
  input  wire logic       clk_out_evt,  // clock-output event (async)
  input  wire logic       backup_sw,    // backup switchover (async)
  input  wire logic [3:0] temp_frac,    // temperature fraction, same clk
  input  wire logic       temp_valid,   // fraction update strobe
  output logic            comp_enable   // temperature compensation on
);
  // refuse counts the 16-bit refresh counter cannot hold
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_busy_chk
    $error("BUSY_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // synchronised pin inputs
  // ------------------------------------------------------------
  logic [3:0] pins_s;       // synchronised async inputs
  logic       low_s;        // supply low level
  logic       fail_s;       // nvm fail level
  logic       clk_evt_s;    // clock event level
  logic       sw_s;         // switchover level
  logic       fail_d_r;     // previous fail level
  logic       clk_evt_d_r;  // previous clock event level
  logic       sw_d_r;       // previous switchover level

  rsf_sync #(.WIDTH(4)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_en  (clk_en),
    .d_async ({supply_low, nvm_fail, clk_out_evt, backup_sw}),
    .q_sync  (pins_s)
  );
  assign {low_s, fail_s, clk_evt_s, sw_s} = pins_s;

  // edge history for event detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fail_d_r    <= 1'b0;
      clk_evt_d_r <= 1'b0;
      sw_d_r      <= 1'b0;
    end else if (clk_en) begin
      fail_d_r    <= fail_s;
      clk_evt_d_r <= clk_evt_s;
      sw_d_r      <= sw_s;
    end
  end

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic wr_status;  // write to status register
  logic wr_temp;    // write to temperature register
  assign wr_status = reg_wr && (reg_addr == `RSF_ADDR_STATUS);
  assign wr_temp   = reg_wr && (reg_addr == `RSF_ADDR_TEMP_LSB);

  // sticky flag: set beats a software clear, writes never set
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr_wr, input logic wbit);
    if (set)
      sticky = 1'b1;
    else if (clr_wr && !wbit)
      sticky = 1'b0;
    else
      sticky = cur;
  endfunction

  // ------------------------------------------------------------
  // status register flags
  // ------------------------------------------------------------
  logic power_on_flag_r;   // set by reset
  logic low_voltage_flag_r; // supply fell below threshold

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_on_flag_r <= `RSF_RST_POWER_ON;
    end else if (clk_en) begin
      // only a write of zero clears it
      power_on_flag_r <= sticky(power_on_flag_r, 1'b0, wr_status,
                           reg_wdata[`RSF_BIT_POWER_ON]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_voltage_flag_r <= `RSF_RST_FLAG;
    end else if (clk_en) begin
      low_voltage_flag_r <= sticky(low_voltage_flag_r, low_s, wr_status,
                              reg_wdata[`RSF_BIT_LOW_VOLT]);
    end
  end

  // compensation halts while supply is low
  assign comp_enable = !low_s;

  // ------------------------------------------------------------
  // temperature register flags
  // ------------------------------------------------------------
  logic       nvm_write_fail_flag_r;    // failed nvm write
  logic       clock_output_event_flag_r; // clock output event
  logic       backup_switch_flag_r;     // switchover happened
  logic [3:0] frac_r;                   // temperature fraction

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nvm_write_fail_flag_r     <= `RSF_RST_FLAG;
      clock_output_event_flag_r <= `RSF_RST_FLAG;
      backup_switch_flag_r      <= `RSF_RST_FLAG;
    end else if (clk_en) begin
      // rising edges set, zero writes clear, ones ignored
      nvm_write_fail_flag_r <= sticky(nvm_write_fail_flag_r,
        fail_s && !fail_d_r, wr_temp,
        reg_wdata[`RSF_BIT_WR_FAIL]);
      clock_output_event_flag_r <= sticky(clock_output_event_flag_r,
        clk_evt_s && !clk_evt_d_r, wr_temp,
        reg_wdata[`RSF_BIT_CLK_EVT]);
      backup_switch_flag_r <= sticky(backup_switch_flag_r,
        sw_s && !sw_d_r, wr_temp,
        reg_wdata[`RSF_BIT_SWITCH]);
    end
  end

  // fraction latched from the sensor, read-only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frac_r <= `RSF_RST_FRAC;
    end else if (clk_en && temp_valid) begin
      frac_r <= temp_frac;
    end
  end

  // ------------------------------------------------------------
  // busy sequencer: memory refresh after reset
  // ------------------------------------------------------------
  rsf_state_t state_r;   // sequencer state
  logic [15:0] busy_cnt_r; // refresh countdown

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r    <= RSF_BOOT;
      busy_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      case (state_r)
        RSF_BOOT: begin
          busy_cnt_r <= 16'(BUSY_CYCLES - 1);
          state_r    <= RSF_BUSY;
        end
        RSF_BUSY: begin
          if (busy_cnt_r == 16'h0000) begin
            state_r <= RSF_IDLE;
          end else begin
            busy_cnt_r <= busy_cnt_r - 16'h0001;
          end
        end
        RSF_IDLE: begin
          state_r <= RSF_IDLE;
        end
        default: begin
          state_r <= RSF_IDLE;
        end
      endcase
    end
  end

  logic nvm_busy_flag;  // high until refresh done, not writable
  assign nvm_busy_flag = (state_r != RSF_IDLE);

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `RSF_ADDR_STATUS: begin
            reg_rdata <= {6'h00, power_on_flag_r, low_voltage_flag_r};
          end
          `RSF_ADDR_TEMP_LSB: begin
            reg_rdata <= {frac_r, nvm_write_fail_flag_r, nvm_busy_flag,
                          clock_output_event_flag_r,
                          backup_switch_flag_r};
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule

/* File: sim/rsf_flags_sva.sv */
// assertion checker for the status and temperature-flag block
`timescale 1ns/1ps
module rsf_flags_sva #(
  parameter int BUSY_CYCLES = 2
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       supply_low,
  input wire logic       nvm_fail,
  input wire logic [3:0] temp_frac,
  input wire logic       temp_valid,
  input wire logic       comp_enable
);
  // ----------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------
  logic rd_en;  // read taken at this edge
  assign rd_en = clk_en && reg_rd;
  int   since_rst;  // enabled edges since reset, saturating

  // count enabled edges so busy timing can be judged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      since_rst <= 0;
    end else if (clk_en && since_rst <= BUSY_CYCLES) begin
      since_rst <= since_rst + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  rvalid_follow_a: assert property (
    rd_en |=> reg_rvalid) else $error("read got no answer");
  rvalid_cause_a: assert property (
    reg_rvalid |-> $past(rd_en)) else $error("answer without read");
  rdata_hold_a: assert property (
    !reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  unmapped_zero_a: assert property (
    rd_en && reg_addr != 8'h0D && reg_addr != 8'h0E |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  comp_off_a: assert property (
    (clk_en && supply_low) [*3] |-> !comp_enable)
    else $error("compensation on at low supply");
  comp_on_a: assert property (
    (clk_en && !supply_low) [*3] |-> comp_enable)
    else $error("compensation off at good supply");
  low_flag_a: assert property (
    (clk_en && supply_low) [*4] ##0 (rd_en && reg_addr == 8'h0D)
    |=> reg_rdata[0]) else $error("low voltage flag not set");
  frac_load_a: assert property (
    clk_en && temp_valid ##1 rd_en && !temp_valid && reg_addr == 8'h0E
    |=> reg_rdata[7:4] == $past(temp_frac, 2)) else $error("bad fraction");
  fail_clear_a: assert property (
    (clk_en && !nvm_fail) [*3] ##0
    (reg_wr && reg_addr == 8'h0E && !reg_wdata[3]) ##2
    (rd_en && reg_addr == 8'h0E) |=> !reg_rdata[3])
    else $error("write fail flag not cleared");
  busy_boot_a: assert property (
    rd_en && reg_addr == 8'h0E && since_rst <= BUSY_CYCLES
    |=> reg_rdata[2]) else $error("busy flag low during refresh");
  busy_done_a: assert property (
    rd_en && reg_addr == 8'h0E && since_rst > BUSY_CYCLES
    |=> !reg_rdata[2]) else $error("busy flag high after refresh");
endmodule
bind rsf_flags rsf_flags_sva #(.BUSY_CYCLES(BUSY_CYCLES)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .supply_low(supply_low),
  .nvm_fail(nvm_fail), .temp_frac(temp_frac), .temp_valid(temp_valid),
  .comp_enable(comp_enable));

/* File: sim/tb_rsf_flags.sv */
// self-checking bench for the status and temperature-flag block
`timescale 1ns/1ps
module tb_rsf_flags;
  logic       clk_sys = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic       supply_low = 0, temp_valid = 0, reg_rvalid, comp_enable;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, e;
  logic [3:0] temp_frac = 0, f;
  logic [2:0] ev = 0;          // write-fail, clock event, switchover
  logic [15:0] q[$], mv;       // expected {mask, value} per read
  int         failures = 0, checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  rsf_flags #(.BUSY_CYCLES(2)) DUT (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .supply_low(supply_low),
    .nvm_fail(ev[2]), .clk_out_evt(ev[1]), .backup_sw(ev[0]),
    .temp_frac(temp_frac), .temp_valid(temp_valid),
    .comp_enable(comp_enable));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task chk(logic [7:0] s, logic [7:0] x);
    checks++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one read, expectation queued for the monitor
  task rd(logic [7:0] a, logic [7:0] x, logic [7:0] m);
    @(posedge clk_sys);
    reg_rd <= 1; temp_valid <= 0; reg_addr <= a;
    q.push_back({m, x});
    @(posedge clk_sys);
    reg_rd <= 0;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // monitor: settled read data against oldest note
  always @(negedge clk_sys) if (reg_rvalid === 1'b1) begin
    if (q.size() == 0) chk(8'h00, 8'h01);
    else begin
      mv = q.pop_front();
      chk(reg_rdata & mv[15:8], mv[7:0]);
    end
  end
  initial begin
    #75000;
    failures++;
    summarize;
  end
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    void'($urandom(70830));
    cyc(4); rst <= 0;
    rd(8'h0E, 8'h04, 8'hFF);
    rd(8'h0D, 8'h02, 8'h03);
    cyc(6);
    rd(8'h0E, 8'h00, 8'hFF);
    wr(8'h0D, 8'h00); rd(8'h0D, 8'h00, 8'h03);
    wr(8'h0E, 8'hFF); rd(8'h0E, 8'h00, 8'hFF);
    rd(8'h33, 8'h00, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      ev[i] <= 1; cyc(2); ev <= 0; cyc(3);
      e = (i == 2) ? 8'h08 : 8'h01 << i;
      rd(8'h0E, e, 8'h0F);
      wr(8'h0E, 8'hFF); rd(8'h0E, e, 8'h0F);
      wr(8'h0E, 8'h00); rd(8'h0E, 8'h00, 8'h0F);
    end
    supply_low <= 1; cyc(4);
    rd(8'h0D, 8'h01, 8'h01);
    @(negedge clk_sys); chk({7'h00, comp_enable}, 8'h00);
    cyc(1); supply_low <= 0; cyc(5);
    @(negedge clk_sys); chk({7'h00, comp_enable}, 8'h01);
    rd(8'h0D, 8'h01, 8'h01);
    wr(8'h0D, 8'h00); rd(8'h0D, 8'h00, 8'h01);
    // frozen clock enable: a low-supply pulse must leave no trace
    cyc(2); clk_en <= 0; supply_low <= 1; cyc(6);
    @(negedge clk_sys); chk({7'h00, comp_enable}, 8'h01);
    cyc(1); supply_low <= 0; cyc(1); clk_en <= 1; cyc(4);
    rd(8'h0D, 8'h00, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      f = 4'($urandom); temp_frac <= f; temp_valid <= 1;
      rd(8'h0E, {f, 4'h0}, 8'hF0);
    end
    cyc(4);
    summarize;
  end
endmodule
